// ==== ftc_top.sv ====
// serial command front end: shifter, decoder, power sequencer
// Notes on behaviour
// - sample serial_data_in on each rising serial clock edge while strobe low and the fifo is not full
// - strobe high resets the shift logic; next low period starts fresh
// - commands arrive msb first; don't care bits are ignored
// - command code leads, followed by command specific parameter bits
// - reset loads defaults into all command registers
// - config command 100: band, divider, load, polarity, step; default 8080
// - band field selects 315, 433, 868 or 915 mhz
// - divider code selects clock output frequency 1 through 10 mhz
// - load trim selects 8.5 to 16.0 pf in half pf steps
// - deviation (step+1)*30 khz, direction polarity xor transmit data pin
// - power command: auto bits 7-6, block bits 5-0, default c000
// - bits 5..1 enable oscillator, synth, amplifier, low battery, wake timer
// - clock output disable bit turns off the clock output buffer
// - auto mode: transmit starts oscillator, then synth, then amplifier after lock
// - memory mode transmit enables synth and amp, stretches clock at header end
// - memory mode: amplifier off once the given byte count is sent
// - oscillator forced on while processing reset or peripheral events
// - with clock output enabled, oscillator stays on until sleep command
// - bits after the transmit code, or after its byte count in memory mode, form the transmit bitstream
// - sleep drops amp and synth at once under their auto bits
`timescale 1ns/1ps
`default_nettype none
module ftc_top (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        serial_clk_i,
    input  wire logic        frame_strobe_n_i,
    input  wire logic        serial_data_in_i,
    input  wire logic        eeprom_mode_i,
    input  wire logic        tx_data_pin_i,
    input  wire logic        event_i,
    input  wire logic        mod_ready_i,
    output logic [1:0]       band_select_o,
    output logic [2:0]       clkout_div_field_o,
    output logic [3:0]       xtal_load_trim_o,
    output logic [2:0]       deviation_step_o,
    output logic             dev_direction_o,
    output logic             osc_on_o,
    output logic             synth_on_o,
    output logic             pa_on_o,
    output logic             lowbat_on_o,
    output logic             wakeup_timer_on_o,
    output logic             clkout_on_o,
    output logic             sclk_stretch_o,
    output logic [7:0]       tx_byte_o,
    output logic             tx_valid_o
);
    // ==========================================================
    // serial capture
    logic        sck_d_ff, nxt_sck_d;
    logic [15:0] shift_ff, nxt_shift;
    logic [4:0]  bits_ff, nxt_bits;
    logic        txs_ff, nxt_txs;
    logic [2:0]  tbit_ff, nxt_tbit;
    logic [7:0]  tcnt_ff, nxt_tcnt;
    logic        tcnt_en_ff, nxt_tcnt_en;
    logic [15:0] cfg_ff, nxt_cfg;
    logic [15:0] pwr_ff, nxt_pwr;
    logic        evt_hold_ff, nxt_evt_hold;
    logic        sleep_p, tx_start_p, sck_rise, push;
    logic [7:0]  push_byte;
    logic [15:0] sh_in;
    logic        fifo_ready, fifo_valid;
    logic [7:0]  fifo_data;
    logic        fifo_take;

    assign sck_rise = serial_clk_i && !sck_d_ff;
    assign sh_in    = {shift_ff[14:0], serial_data_in_i}; // msb first

    always_comb begin
        nxt_sck_d   = serial_clk_i;
        nxt_shift   = shift_ff;
        nxt_bits    = bits_ff;
        nxt_txs     = txs_ff;
        nxt_tbit    = tbit_ff;
        nxt_tcnt    = tcnt_ff;
        nxt_tcnt_en = tcnt_en_ff;
        nxt_cfg     = cfg_ff;
        nxt_pwr     = pwr_ff;
        sleep_p     = 1'b0;
        tx_start_p  = 1'b0;
        push        = 1'b0;
        push_byte   = sh_in[7:0];
        if (frame_strobe_n_i) begin
            nxt_bits = '0;
            nxt_txs  = 1'b0;
            nxt_tbit = '0;
        end else if (sck_rise && fifo_ready) begin
            nxt_shift = sh_in;
            if (txs_ff) begin
                // payload bytes after the transmit header
                nxt_tbit = tbit_ff + 3'h1;
                if (tbit_ff == 3'h7) begin
                    push = 1'b1;
                    if (tcnt_en_ff && tcnt_ff != 8'h00) begin
                        nxt_tcnt = tcnt_ff - 8'h01;
                    end
                end
            end else begin
                nxt_bits = bits_ff + 5'h01;
                // transmit header decodes after 8 bits outside memory mode; the rest only once the whole command is in
                if (nxt_bits == ftc_pkg::HDR_BITS && sh_in[7:0] == ftc_pkg::TX_CODE
                        && !eeprom_mode_i) begin
                    nxt_txs    = 1'b1;
                    tx_start_p = 1'b1;
                    nxt_tcnt_en = 1'b0;
                end
                if (nxt_bits == ftc_pkg::CMD_BITS) begin
                    nxt_bits = '0; // byte multiples only; next command follows
                    if (sh_in[15:13] == ftc_pkg::CFG_CODE) begin
                        nxt_cfg = sh_in;
                    end else if (sh_in[15:8] == ftc_pkg::PWR_CODE) begin
                        nxt_pwr = sh_in;
                    end else if (sh_in[15:8] == ftc_pkg::SLEEP_CODE) begin
                        sleep_p = 1'b1;
                    end else if (sh_in[15:8] == ftc_pkg::TX_CODE && eeprom_mode_i) begin
                        nxt_txs     = 1'b1; // byte count in low byte
                        tx_start_p  = 1'b1;
                        nxt_tcnt    = sh_in[7:0];
                        nxt_tcnt_en = 1'b1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // event hold for oscillator
    always_comb begin
        nxt_evt_hold = evt_hold_ff;
        if (sleep_p) begin
            nxt_evt_hold = 1'b0; // sleep resets event logic
        end
        if (event_i && !pwr_ff[ftc_pkg::CLK_DIS]) begin
            nxt_evt_hold = 1'b1; // event set wins over sleep clear
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sck_d_ff    <= 1'b0;
            shift_ff    <= '0;
            bits_ff     <= '0;
            txs_ff      <= 1'b0;
            tbit_ff     <= '0;
            tcnt_ff     <= '0;
            tcnt_en_ff  <= 1'b0;
            cfg_ff      <= ftc_pkg::CFG_RESET;
            pwr_ff      <= ftc_pkg::PWR_RESET;
            evt_hold_ff <= 1'b1; // power-on reset is itself an event
        end else begin
            sck_d_ff    <= nxt_sck_d;
            shift_ff    <= nxt_shift;
            bits_ff     <= nxt_bits;
            txs_ff      <= nxt_txs;
            tbit_ff     <= nxt_tbit;
            tcnt_ff     <= nxt_tcnt;
            tcnt_en_ff  <= nxt_tcnt_en;
            cfg_ff      <= nxt_cfg;
            pwr_ff      <= nxt_pwr;
            evt_hold_ff <= nxt_evt_hold;
        end
    end

    // ==========================================================
    // payload fifo; a full fifo stalls sampling of new bits
    // the output stage refills only when empty or taken, keeping valid and data coherent
    assign fifo_take = !tx_valid_o || mod_ready_i;

    ftc_fifo #(
        .W (ftc_pkg::FIFO_W),
        .D (ftc_pkg::FIFO_D)
    ) u_fifo (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .flush_i     (1'b0),
        .in_data_i   (push_byte),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_take)
    );

    // ==========================================================
    // automatic power sequencer
    ftc_pkg::ftc_seq_t seq_ff, nxt_seq;
    logic        dly_start;
    logic [31:0] dly_cycles;
    logic        dly_done;
    logic        a_osc, a_syn, a_pa;

    ftc_delay u_delay (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .start_i  (dly_start),
        .cycles_i (dly_cycles),
        .done_o   (dly_done)
    );

    always_comb begin
        nxt_seq    = seq_ff;
        dly_start  = 1'b0;
        dly_cycles = 32'(ftc_pkg::OSC_CYC);
        unique case (seq_ff)
            ftc_pkg::SEQ_IDLE: begin
                if (tx_start_p && (pwr_ff[ftc_pkg::AUTO_OS] || eeprom_mode_i)) begin
                    nxt_seq   = ftc_pkg::SEQ_OSC;
                    dly_start = 1'b1;
                end
            end
            ftc_pkg::SEQ_OSC: begin
                if (dly_done) begin
                    nxt_seq    = ftc_pkg::SEQ_SYN;
                    dly_start  = 1'b1;
                    dly_cycles = 32'(ftc_pkg::SYN_CYC);
                end
            end
            ftc_pkg::SEQ_SYN: begin
                if (dly_done) begin
                    nxt_seq    = ftc_pkg::SEQ_LOCK;
                    dly_start  = 1'b1;
                    dly_cycles = 32'(ftc_pkg::LOCK_CYC);
                end
            end
            ftc_pkg::SEQ_LOCK: begin
                if (dly_done) begin
                    nxt_seq = ftc_pkg::SEQ_RUN;
                end
            end
            ftc_pkg::SEQ_RUN: begin
                // byte count exhausted in memory mode
                if (tcnt_en_ff && tcnt_ff == 8'h00 && !fifo_valid) begin
                    nxt_seq = ftc_pkg::SEQ_IDLE;
                end
            end
            default: nxt_seq = ftc_pkg::SEQ_IDLE;
        endcase
        if (sleep_p) begin
            nxt_seq = ftc_pkg::SEQ_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            seq_ff <= ftc_pkg::SEQ_IDLE;
        end else begin
            seq_ff <= nxt_seq;
        end
    end

    // enable bits stay zero under auto control, host's own duty
    assign a_osc = (seq_ff != ftc_pkg::SEQ_IDLE);
    assign a_syn = (seq_ff == ftc_pkg::SEQ_SYN) || (seq_ff == ftc_pkg::SEQ_LOCK)
                   || (seq_ff == ftc_pkg::SEQ_RUN);
    assign a_pa  = (seq_ff == ftc_pkg::SEQ_RUN)
                   && (pwr_ff[ftc_pkg::AUTO_PA] || eeprom_mode_i);

    // ==========================================================
    // registered outputs
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            band_select_o      <= '0;
            clkout_div_field_o <= '0;
            xtal_load_trim_o   <= '0;
            deviation_step_o   <= '0;
            dev_direction_o    <= 1'b0;
            osc_on_o           <= 1'b0;
            synth_on_o         <= 1'b0;
            pa_on_o            <= 1'b0;
            lowbat_on_o        <= 1'b0;
            wakeup_timer_on_o  <= 1'b0;
            clkout_on_o        <= 1'b0;
            sclk_stretch_o     <= 1'b0;
            tx_byte_o          <= '0;
            tx_valid_o         <= 1'b0;
        end else begin
            band_select_o      <= cfg_ff[ftc_pkg::BAND_HI:ftc_pkg::BAND_LO];
            clkout_div_field_o <= cfg_ff[ftc_pkg::DIV_HI:ftc_pkg::DIV_LO];
            xtal_load_trim_o   <= cfg_ff[ftc_pkg::XTAL_HI:ftc_pkg::XTAL_LO];
            deviation_step_o   <= cfg_ff[ftc_pkg::DEV_HI:ftc_pkg::DEV_LO];
            dev_direction_o    <= cfg_ff[ftc_pkg::DEV_POL] ^ tx_data_pin_i;
            // oscillator forced on during events
            osc_on_o           <= pwr_ff[ftc_pkg::OSC_EN] || a_osc || event_i
                                  || evt_hold_ff;
            synth_on_o         <= pwr_ff[ftc_pkg::SYN_EN] || a_syn;
            pa_on_o            <= pwr_ff[ftc_pkg::PA_EN] || a_pa;
            lowbat_on_o        <= pwr_ff[ftc_pkg::LB_EN];
            wakeup_timer_on_o  <= pwr_ff[ftc_pkg::WT_EN];
            clkout_on_o        <= !pwr_ff[ftc_pkg::CLK_DIS];
            // hold the serial clock at header end until power is up
            sclk_stretch_o     <= eeprom_mode_i && txs_ff
                                  && (seq_ff != ftc_pkg::SEQ_RUN);
            // a held byte leaves only when taken, so none is lost or repeated
            if (fifo_take) begin
                tx_byte_o  <= fifo_data;
                tx_valid_o <= fifo_valid;
            end
        end
    end
endmodule
`default_nettype wire

// ==== ftc_pkg.sv ====
// shared constants and types for the fsk transmitter command front end
package ftc_pkg;
    // ==========================================================
    // command codes and defaults
    localparam logic [15:0] CFG_RESET   = 16'h8080;
    localparam logic [15:0] PWR_RESET   = 16'hc000;
    localparam logic [2:0]  CFG_CODE    = 3'h4;
    localparam logic [7:0]  PWR_CODE    = 8'hc0;
    localparam logic [7:0]  TX_CODE     = 8'hc6;
    localparam logic [7:0]  SLEEP_CODE  = 8'hc4;
    localparam logic [4:0]  CMD_BITS    = 5'h10;
    localparam logic [4:0]  HDR_BITS    = 5'h08;
    // ==========================================================
    // field positions
    localparam int BAND_HI  = 12;
    localparam int BAND_LO  = 11;
    localparam int DIV_HI   = 10;
    localparam int DIV_LO   = 8;
    localparam int XTAL_HI  = 7;
    localparam int XTAL_LO  = 4;
    localparam int DEV_POL  = 3;
    localparam int DEV_HI   = 2;
    localparam int DEV_LO   = 0;
    localparam int AUTO_OS  = 7;
    localparam int AUTO_PA  = 6;
    localparam int OSC_EN   = 5;
    localparam int SYN_EN   = 4;
    localparam int PA_EN    = 3;
    localparam int LB_EN    = 2;
    localparam int WT_EN    = 1;
    localparam int CLK_DIS  = 0;
    // ==========================================================
    // timing
    localparam int CLK_MHZ       = 50;
    localparam int OSC_START_US  = 5000;
    localparam int LOCK_US       = 20;
    localparam int SYN_START_US  = 250;
    localparam int OSC_CYC       = OSC_START_US * CLK_MHZ;
    localparam int LOCK_CYC      = LOCK_US * CLK_MHZ;
    localparam int SYN_CYC       = SYN_START_US * CLK_MHZ;
    localparam int FIFO_W        = 8;
    localparam int FIFO_D        = 16;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_OSC  = 3'b001,
        SEQ_SYN  = 3'b010,
        SEQ_LOCK = 3'b011,
        SEQ_RUN  = 3'b100
    } ftc_seq_t;
endpackage

// ==== ftc_fifo.sv ====
// parameterised valid/ready fifo held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module ftc_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic         flush_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_ff [D];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0]   cnt_ff, nxt_cnt;
    logic          push, pop;

    always_comb begin
        push    = in_valid_i && (cnt_ff != (AW+1)'(D));
        pop     = out_ready_i && (cnt_ff != '0);
        nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            nxt_wr  = '0;
            nxt_rd  = '0;
            nxt_cnt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end

    assign in_ready_o  = (cnt_ff != (AW+1)'(D));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o  = mem_ff[rd_ff];
endmodule
`default_nettype wire

// ==== ftc_delay.sv ====
// one-shot delay counter for the power-up sequencer
`timescale 1ns/1ps
`default_nettype none
module ftc_delay (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        start_i,
    input  wire logic [31:0] cycles_i,
    output logic             done_o
);
    logic [31:0] cnt_ff, nxt_cnt;
    logic        run_ff, nxt_run;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_run = run_ff;
        if (start_i) begin
            nxt_cnt = cycles_i;
            nxt_run = 1'b1;
        end else if (run_ff) begin
            if (cnt_ff <= 32'h1) begin
                nxt_run = 1'b0;
            end
            nxt_cnt = cnt_ff - 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            run_ff <= nxt_run;
        end
    end

    assign done_o = run_ff && (cnt_ff <= 32'h1) && !start_i;
endmodule
`default_nettype wire

// ==== ftc_host_model.sv ====
// host controller model driving framed serial commands into the front end
`timescale 1ns/1ps
`default_nettype none
module ftc_host_model (
    input  wire logic clk_i,
    output logic      serial_clk_o,
    output logic      frame_strobe_n_o,
    output logic      serial_data_o
);
    // ==========================================================
    // idle levels: serial clock parked low outside frames
    initial begin
        serial_clk_o     = 1'b0;
        frame_strobe_n_o = 1'b1;
        serial_data_o    = 1'b0;
    end
    // ==========================================================
    // frame control
    task automatic open_frame;
        @(posedge clk_i);
        frame_strobe_n_o <= 1'b0;
    endtask
    task automatic close_frame;
        repeat (2) @(posedge clk_i);
        frame_strobe_n_o <= 1'b1;
        // released line: show the inverse so a stale bit cannot pass for data
        serial_data_o    <= ~serial_data_o;
        repeat (3) @(posedge clk_i);
    endtask
    // whole bytes only, msb first, clock high two system cycles, low three
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_i);
            serial_data_o <= b[i];
            repeat (2) @(posedge clk_i);
            serial_clk_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            serial_clk_o <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== ftc_top_asserts.sv ====
// concurrent checks on the command front end ports
`timescale 1ns/1ps
`default_nettype none
module ftc_top_chk (
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic       serial_clk_i,
    input wire logic       frame_strobe_n_i,
    input wire logic       serial_data_in_i,
    input wire logic       eeprom_mode_i,
    input wire logic       tx_data_pin_i,
    input wire logic       event_i,
    input wire logic       mod_ready_i,
    input wire logic [1:0] band_select_o,
    input wire logic [2:0] clkout_div_field_o,
    input wire logic [3:0] xtal_load_trim_o,
    input wire logic [2:0] deviation_step_o,
    input wire logic       dev_direction_o,
    input wire logic       osc_on_o,
    input wire logic       synth_on_o,
    input wire logic       pa_on_o,
    input wire logic       lowbat_on_o,
    input wire logic       wakeup_timer_on_o,
    input wire logic       clkout_on_o,
    input wire logic       sclk_stretch_o,
    input wire logic [7:0] tx_byte_o,
    input wire logic       tx_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ==========================================================
    // register loading and update moments
    cfg_defaults_a: assert property (disable iff (1'b0)
        !rstn_i ##1 rstn_i [*3] |-> band_select_o == 2'h0 && xtal_load_trim_o == 4'h8
            && clkout_on_o && osc_on_o)
        else $error("defaults not loaded after reset");
    cfg_apply_a: assert property (
        $past(rstn_i, 2) && $past(rstn_i, 3) && ($changed(band_select_o)
            || $changed(clkout_div_field_o) || $changed(xtal_load_trim_o)
            || $changed(deviation_step_o)) |-> $past(frame_strobe_n_i) == 1'b0)
        else $error("config fields changed outside a frame");
    clkout_apply_a: assert property (
        frame_strobe_n_i [*3] |=> $stable(clkout_on_o))
        else $error("clock output buffer moved while idle");
    blocks_apply_a: assert property (
        $past(rstn_i, 2) && ($changed(lowbat_on_o) || $changed(wakeup_timer_on_o))
            |-> $past(frame_strobe_n_i) == 1'b0)
        else $error("block enable moved outside a frame");
    // ==========================================================
    // deviation direction, oscillator control and clock stretch
    dir_follow_a: assert property (
        $past(rstn_i) && frame_strobe_n_i && $past(frame_strobe_n_i)
            && $changed(tx_data_pin_i) |=> $changed(dev_direction_o))
        else $error("direction did not follow the data pin");
    event_osc_a: assert property (
        event_i |-> ##[1:3] osc_on_o)
        else $error("oscillator not forced on by event");
    osc_hold_a: assert property (
        $fell(osc_on_o) && $past(clkout_on_o, 2) |-> $past(frame_strobe_n_i) == 1'b0
            && $past(event_i) == 1'b0)
        else $error("oscillator dropped without a command");
    stretch_off_a: assert property (
        !eeprom_mode_i && !$past(eeprom_mode_i) |-> !sclk_stretch_o)
        else $error("clock stretch outside memory mode");
    cfg_seen_c: cover property ($changed(band_select_o));
    osc_drop_c: cover property ($fell(osc_on_o));
    payload_c:  cover property (tx_valid_o && mod_ready_i);
endmodule
bind ftc_top ftc_top_chk u_chk (.*);
`default_nettype wire

// ==== ftc_tb.sv ====
// self-checking testbench for the serial command front end
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_i, rstn_i, serial_clk_i, frame_strobe_n_i, serial_data_in_i;
    logic        eeprom_mode_i, tx_data_pin_i, event_i, mod_ready_i;
    logic [1:0]  band_select_o;
    logic [2:0]  clkout_div_field_o, deviation_step_o;
    logic [3:0]  xtal_load_trim_o;
    logic        dev_direction_o, osc_on_o, synth_on_o, pa_on_o, lowbat_on_o;
    logic        wakeup_timer_on_o, clkout_on_o, sclk_stretch_o, tx_valid_o;
    logic [7:0]  tx_byte_o;
    logic [7:0]  exp_q[$];
    logic [7:0]  pw[3] = '{8'h27, 8'h39, 8'h00};
    logic [15:0] c;
    int          errors, check_count, seed, n;

    ftc_top dut (.*);
    ftc_host_model host (
        .clk_i            (clk_i),
        .serial_clk_o     (serial_clk_i),
        .frame_strobe_n_o (frame_strobe_n_i),
        .serial_data_o    (serial_data_in_i)
    );
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // ==========================================================
    // comparison, closing report and command helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmd(input logic [15:0] v);
        host.open_frame();
        host.send_byte(v[15:8]);
        host.send_byte(v[7:0]);
        host.close_frame();
    endtask
    task automatic chk_cfg(input logic [15:0] v);
        check({4'h0, band_select_o, clkout_div_field_o, xtal_load_trim_o, deviation_step_o},
              {4'h0, v[12:4], v[2:0]});
    endtask
    task automatic chk_pwr(input logic [7:0] p, input logic osc);
        check({10'h0, osc_on_o, synth_on_o, pa_on_o, lowbat_on_o, wakeup_timer_on_o,
               clkout_on_o}, {10'h0, osc, p[4:1], ~p[0]});
    endtask
    // ==========================================================
    // payload watcher: oldest note against each accepted byte
    always @(posedge clk_i) begin
        if (tx_valid_o === 1'b1 && mod_ready_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("ERROR %0t: unexpected payload byte", $time);
            end else begin
                check({8'h0, tx_byte_o}, {8'h0, exp_q.pop_front()});
            end
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        seed = 44;
        rstn_i = 1'b0;
        eeprom_mode_i = 1'b0;
        tx_data_pin_i = 1'b0;
        event_i = 1'b0;
        mod_ready_i = 1'b1;
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_cfg(ftc_pkg::CFG_RESET);
        chk_pwr(ftc_pkg::PWR_RESET[7:0], 1'b1);
        $display("test defaults done");
        // every band and divider code with random load and deviation
        for (int i = 0; i < 8; i++) begin
            c = {ftc_pkg::CFG_CODE, i[1:0], i[2:0], 8'($random(seed))};
            cmd(c);
            chk_cfg(c);
            for (int p = 0; p < 2; p++) begin
                tx_data_pin_i <= p[0];
                repeat (2) @(posedge clk_i);
                check({15'h0, dev_direction_o}, {15'h0, c[3] ^ p[0]});
            end
        end
        $display("test config done");
        // half a command then strobe high must leave nothing behind
        host.open_frame();
        host.send_byte(8'h9f);
        host.close_frame();
        chk_cfg(c);
        // config and power back to back in one frame
        c = 16'h9bf5;
        host.open_frame();
        host.send_byte(c[15:8]);
        host.send_byte(c[7:0]);
        host.send_byte(ftc_pkg::PWR_CODE);
        host.send_byte(8'h3e);
        host.close_frame();
        chk_cfg(c);
        chk_pwr(8'h3e, 1'b1);
        // oscillator expected on each time: 27 and 39 set its bit, 00 leaves it to the event hold
        for (int i = 0; i < 3; i++) begin
            cmd({ftc_pkg::PWR_CODE, pw[i]});
            chk_pwr(pw[i], 1'b1);
        end
        $display("test power done");
        cmd({ftc_pkg::SLEEP_CODE, 8'h00});
        chk_pwr(8'h00, 1'b0);
        event_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_pwr(8'h00, 1'b1);
        event_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk_pwr(8'h00, 1'b1);
        cmd({ftc_pkg::SLEEP_CODE, 8'h00});
        chk_pwr(8'h00, 1'b0);
        $display("test events done");
        // queue FIFO_D payload bytes with the far side stalled, then drain
        mod_ready_i <= 1'b0;
        host.open_frame();
        host.send_byte(ftc_pkg::TX_CODE); // power enables left at zero
        repeat (ftc_pkg::FIFO_D) begin
            n = $random(seed);
            exp_q.push_back(n[7:0]);
            host.send_byte(n[7:0]);
        end
        host.close_frame();
        n = 0;
        while (exp_q.size() != 0 && n < 2000) begin
            @(posedge clk_i);
            mod_ready_i <= 1'($random(seed));
            n++;
        end
        if (n >= 2000) begin
            errors++;
            $display("ERROR %0t: payload drain timed out", $time);
            finish_test();
        end
        mod_ready_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        check({15'h0, tx_valid_o}, 16'h0000);
        // sleep marks the end of a transmission
        cmd({ftc_pkg::SLEEP_CODE, 8'h00});
        chk_pwr(8'h00, 1'b0);
        $display("test payload done");
        finish_test();
    end
endmodule
`default_nettype wire
